// File: pkg/eewc_pkg.sv
package eewc_pkg;

  // clock rate of pclk
  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned CLK_NS            = 40;

  // strobe and page timing, figures in their own units
  localparam int unsigned WE_PULSE_NS       = 100;
  localparam int unsigned GLITCH_NS         = 20;
  localparam int unsigned BYTE_LOAD_MAX_US  = 30;
  localparam int unsigned BYTE_LOAD_WIN_US  = 100;
  localparam int unsigned WRITE_CYCLE_MS    = 10;
  localparam int unsigned RESET_HOLD_MS     = 10;

  // derived cycle counts: least times round up, the byte load limit is taken at half its length
  localparam int unsigned WE_PULSE_CYC      = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GLITCH_CYC        = GLITCH_NS / CLK_NS + 1;
  localparam int unsigned BYTE_GAP_CYC      = BYTE_LOAD_MAX_US * (CLK_HZ / 1_000_000) / 2;
  localparam int unsigned LOAD_WIN_CYC      = BYTE_LOAD_WIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WRITE_CYC         = WRITE_CYCLE_MS * (CLK_HZ / 1_000);
  localparam int unsigned RESET_HOLD_CYC    = RESET_HOLD_MS * (CLK_HZ / 1_000);

  // device geometry
  localparam int unsigned ADDR_W            = 15;
  localparam int unsigned PAGE_BYTES        = 64;
  localparam int unsigned PAGE_IDX_W        = 6;

  // software lock command words
  localparam logic [14:0] CMD_ADDR_A        = 15'h5555;
  localparam logic [14:0] CMD_ADDR_B        = 15'h2AAA;
  localparam logic [7:0]  CMD_DAT_AA        = 8'hAA;
  localparam logic [7:0]  CMD_DAT_55        = 8'h55;
  localparam logic [7:0]  CMD_DAT_LOCK      = 8'hA0;
  localparam logic [7:0]  CMD_DAT_80        = 8'h80;
  localparam logic [7:0]  CMD_DAT_UNLOCK    = 8'h20;

  // apb register offsets of the controller
  localparam logic [11:0] REG_CTRL          = 12'h000;
  localparam logic [11:0] REG_ADDR          = 12'h004;
  localparam logic [11:0] REG_DATA          = 12'h008;
  localparam logic [11:0] REG_STATUS        = 12'h00C;
  localparam logic [11:0] REG_RDATA         = 12'h010;

  // control fields
  localparam int unsigned CTRL_GO_BIT       = 0;
  localparam int unsigned CTRL_OP_LSB       = 1;
  localparam int unsigned CTRL_PROT_BIT     = 4;
  localparam int unsigned CTRL_LEN_LSB      = 8;

  // status fields
  localparam int unsigned ST_BUSY_BIT       = 0;
  localparam int unsigned ST_RDY_BIT        = 1;
  localparam int unsigned ST_TMO_BIT        = 2;
  localparam int unsigned ST_TOG_BIT        = 3;

  // reset values
  localparam logic [31:0] CTRL_RST          = 32'h0000_0000;

  // commands given by software
  typedef enum logic [2:0] {
    EEWC_OP_WRITE  = 3'h0,
    EEWC_OP_READ   = 3'h1,
    EEWC_OP_LOCK   = 3'h2,
    EEWC_OP_UNLOCK = 3'h3,
    EEWC_OP_LWRITE = 3'h4
  } eewc_op_t;

endpackage

// File: hw/eewc_strobe.sv
`timescale 1ns/1ps
`default_nettype none
// one byte cycle on the parallel bus: address out, strobe low, strobe high, data hold
module eewc_strobe (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic        is_read,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  dq_in,
  output logic             done,
  output logic [7:0]       rdata_q,
  output logic [14:0]      a_q,
  output logic [7:0]       dq_out_q,
  output logic             dq_oe_q,
  output logic             ce_n_q,
  output logic             oe_n_q,
  output logic             we_n_q
);
  import eewc_pkg::*;

  typedef enum logic [1:0] {EEWC_S_IDLE, EEWC_S_SET, EEWC_S_LOW, EEWC_S_HOLD} eewc_sst_t;
  eewc_sst_t   st_q;                   // byte cycle state
  logic [3:0]  cnt_q;                  // strobe width counter

  // strobe wider than the glitch filter, so no pulse is rejected
  localparam logic [3:0] LOW_CYC = 4'(WE_PULSE_CYC > GLITCH_CYC ? WE_PULSE_CYC : GLITCH_CYC + 1);

  // sequencing of one byte cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= EEWC_S_IDLE;
      cnt_q    <= 4'h0;
      ce_n_q   <= 1'b1;
      oe_n_q   <= 1'b1;
      we_n_q   <= 1'b1;
      dq_oe_q  <= 1'b0;
      a_q      <= 15'h0000;
      dq_out_q <= 8'h00;
      rdata_q  <= 8'h00;
    end else begin
      case (st_q)
        EEWC_S_IDLE: begin
          if (start) begin
            // address and data set before the strobe falls
            a_q      <= addr;
            dq_out_q <= wdata;
            dq_oe_q  <= !is_read;
            oe_n_q   <= !is_read;      // oe high during writes
            ce_n_q   <= 1'b0;
            st_q     <= EEWC_S_SET;
          end
        end
        EEWC_S_SET: begin
          // we falls after ce: address taken on this later edge
          we_n_q <= is_read;
          cnt_q  <= LOW_CYC;
          st_q   <= EEWC_S_LOW;
        end
        EEWC_S_LOW: begin
          if (cnt_q == 4'h1) begin
            if (is_read) begin
              rdata_q <= dq_in;
            end
            we_n_q <= 1'b1;            // data taken on this rising edge
            oe_n_q <= 1'b1;
            st_q   <= EEWC_S_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          // release ce one cycle after we, keeping data hold
          ce_n_q  <= 1'b1;
          dq_oe_q <= 1'b0;
          st_q    <= EEWC_S_IDLE;
        end
      endcase
    end
  end

  assign done = (st_q == EEWC_S_HOLD);

endmodule
`default_nettype wire

// File: hw/eewc_ctrl.sv
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - next byte starts within 30 us
// - keep protect/reset high through every operation
// - hold protect/reset high 10 ms after data
// - lock: AA, 55, A0, then data write
// - when locked, every write needs the codes
// - unlock with the six-write sequence
module eewc_ctrl (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // device pins
  output logic      [eewc_pkg::ADDR_W-1:0]  mem_addr,
  input  wire logic [7:0]                   mem_dq_in,
  output logic      [7:0]                   mem_dq_out,
  output logic                              mem_dq_oe,
  output logic                              mem_ce_n,
  output logic                              mem_oe_n,
  output logic                              mem_we_n,
  output logic                              protect_reset_n,
  input  wire logic                         ready_busy_n
);
  import eewc_pkg::*;

  typedef enum logic [2:0] {
    EEWC_IDLE, EEWC_CODE, EEWC_LOAD, EEWC_GAP, EEWC_POLL, EEWC_HOLD
  } eewc_st_t;

  eewc_st_t    st_q;                   // main sequencer state
  logic [31:0] ctrl_q;                 // control register
  logic [14:0] addr_q;                 // start address of page
  logic [7:0]  page_q [PAGE_BYTES];    // page buffer, software fills by index
  logic [5:0]  widx_q;                 // software fill pointer
  logic [6:0]  bidx_q;                 // bytes sent in this load
  logic [2:0]  cidx_q;                 // command word index
  logic [23:0] tmr_q;                  // gap, poll and hold timer
  logic        tmo_q;                  // sticky timeout flag
  logic        tog_q;                  // toggle seen during this operation
  logic [7:0]  last_q;                 // last byte loaded
  logic [7:0]  prev_q;                 // previous poll read
  logic        pfirst_q;               // first poll read pending
  logic        go_q;                   // start pulse from a ctrl write
  logic        bstart;                 // byte cycle request
  logic        bread;                  // byte cycle is a read
  logic [14:0] baddr;                  // byte cycle address
  logic [7:0]  bdata;                  // byte cycle data
  logic        bdone;                  // byte cycle finished
  logic [7:0]  brd;                    // byte cycle read data
  logic        bidle_q;                // byte engine free
  logic [2:0]  ncode;                  // command words for this op
  logic [6:0]  plen;                   // page length, 1 to 64

  eewc_op_t op;
  assign op   = eewc_op_t'(ctrl_q[CTRL_OP_LSB +: 3]);
  // zero length reads as a full page; longer asks are clipped to 64
  assign plen = (ctrl_q[CTRL_LEN_LSB +: 7] == 7'h00 || ctrl_q[CTRL_LEN_LSB +: 7] > 7'd64) ?
                7'd64 : ctrl_q[CTRL_LEN_LSB +: 7];

  // command word count: lock prefix is three, unlock is six
  always_comb begin
    ncode = 3'd0;
    if (op == EEWC_OP_LOCK || op == EEWC_OP_LWRITE) begin
      ncode = 3'd3;
    end else if (op == EEWC_OP_UNLOCK) begin
      ncode = 3'd6;
    end
  end

  // command table, address and data for word i
  function automatic logic [22:0] eewc_code(input logic [2:0] i, input logic unl);
    logic [22:0] r;
    r = {CMD_ADDR_A, CMD_DAT_AA};
    case (i)
      3'd1: r = {CMD_ADDR_B, CMD_DAT_55};
      3'd2: r = {CMD_ADDR_A, unl ? CMD_DAT_80 : CMD_DAT_LOCK};
      3'd3: r = {CMD_ADDR_A, CMD_DAT_AA};
      3'd4: r = {CMD_ADDR_B, CMD_DAT_55};
      3'd5: r = {CMD_ADDR_A, CMD_DAT_UNLOCK};
      default: r = {CMD_ADDR_A, CMD_DAT_AA};
    endcase
    return r;
  endfunction

  // apb: zero wait, every access answered in its access cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == REG_CTRL) begin
      prdata = ctrl_q;
    end else if (paddr == REG_ADDR) begin
      prdata = {17'h00000, addr_q};
    end else if (paddr == REG_STATUS) begin
      prdata = {28'h0000000, tog_q, tmo_q, ready_busy_n, st_q != EEWC_IDLE};
    end else if (paddr == REG_RDATA) begin
      prdata = {24'h000000, brd};
    end
  end

  // software register writes; go is a one-cycle pulse, ignored while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      addr_q <= 15'h0000;
      widx_q <= 6'h00;
      go_q   <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (psel && penable && pwrite) begin
        if (paddr == REG_CTRL) begin
          ctrl_q <= pwdata & 32'h0000_7F1E;
          go_q   <= pwdata[CTRL_GO_BIT] && (st_q == EEWC_IDLE);
        end else if (paddr == REG_ADDR) begin
          addr_q <= pwdata[14:0];
          widx_q <= 6'h00;             // address write rewinds the fill pointer
        end else if (paddr == REG_DATA) begin
          widx_q <= widx_q + 6'h01;
        end
      end
    end
  end

  // page buffer storage, addressed by the fill pointer
  always_ff @(posedge pclk) begin
    if (psel && penable && pwrite && paddr == REG_DATA) begin
      page_q[widx_q] <= pwdata[7:0];
    end
  end

  // protect/reset follows the control bit; a 10 ms hold stands after loads
  assign protect_reset_n = ctrl_q[CTRL_PROT_BIT] || (st_q != EEWC_IDLE);

  // byte cycle mux: command words, page bytes or poll reads
  always_comb begin
    bread = (st_q == EEWC_POLL) || (st_q == EEWC_LOAD && op == EEWC_OP_READ);
    baddr = {addr_q[14:6], addr_q[5:0] + bidx_q[5:0]}; // page row fixed for the load
    bdata = page_q[bidx_q[5:0]];
    if (st_q == EEWC_POLL) begin
      // poll the last loaded byte: any other cell shows its own old bit seven
      baddr[5:0] = addr_q[5:0] + bidx_q[5:0] - 6'h01;
    end
    if (st_q == EEWC_CODE) begin
      {baddr, bdata} = eewc_code(cidx_q, op == EEWC_OP_UNLOCK);
    end
    bstart = bidle_q && (st_q == EEWC_CODE || st_q == EEWC_LOAD || st_q == EEWC_POLL)
             && (st_q != EEWC_POLL || tmr_q[3:0] == 4'h0);
  end

  eewc_strobe u_strobe (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (bstart),
    .is_read  (bread),
    .addr     (baddr),
    .wdata    (bdata),
    .dq_in    (mem_dq_in),
    .done     (bdone),
    .rdata_q  (brd),
    .a_q      (mem_addr),
    .dq_out_q (mem_dq_out),
    .dq_oe_q  (mem_dq_oe),
    .ce_n_q   (mem_ce_n),
    .oe_n_q   (mem_oe_n),
    .we_n_q   (mem_we_n)
  );

  // byte engine is busy from start until done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bidle_q <= 1'b1;
    end else if (bstart) begin
      bidle_q <= 1'b0;
    end else if (bdone) begin
      bidle_q <= 1'b1;
    end
  end

  // main sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= EEWC_IDLE;
      cidx_q   <= 3'd0;
      bidx_q   <= 7'd0;
      tmr_q    <= 24'd0;
      tmo_q    <= 1'b0;
      tog_q    <= 1'b0;
      last_q   <= 8'h00;
      prev_q   <= 8'h00;
      pfirst_q <= 1'b0;
    end else begin
      case (st_q)
        EEWC_IDLE: begin
          if (go_q) begin
            cidx_q <= 3'd0;
            bidx_q <= 7'd0;
            tmo_q  <= 1'b0;
            tog_q  <= 1'b0;
            tmr_q  <= 24'd0;           // stale count would flag a late first byte
            st_q   <= (ncode != 3'd0) ? EEWC_CODE : EEWC_LOAD;
          end
        end
        EEWC_CODE: begin
          if (bdone) begin
            cidx_q <= cidx_q + 3'd1;
            if (cidx_q + 3'd1 == ncode) begin
              // unlock words are never followed by data
              st_q <= (op == EEWC_OP_UNLOCK) ? EEWC_GAP : EEWC_LOAD;
            end
          end
        end
        EEWC_LOAD: begin
          tmr_q <= tmr_q + 24'd1;
          if (bdone) begin
            tmr_q  <= 24'd0;
            bidx_q <= bidx_q + 7'd1;
            last_q <= bdata;
            if (op == EEWC_OP_READ) begin
              st_q <= EEWC_IDLE;
            end else if (bidx_q + 7'd1 == plen) begin
              st_q <= EEWC_GAP;
            end
          end else if (tmr_q >= 24'(BYTE_GAP_CYC)) begin
            tmo_q <= 1'b1;             // next byte late, device may have started
          end
        end
        EEWC_GAP: begin
          // strobes stay high for the load window so the device starts writing
          tmr_q <= tmr_q + 24'd1;
          if (tmr_q >= 24'(LOAD_WIN_CYC)) begin
            tmr_q    <= 24'd0;
            pfirst_q <= 1'b1;
            st_q     <= EEWC_POLL;
          end
        end
        EEWC_POLL: begin
          tmr_q <= tmr_q + 24'd1;
          if (bdone) begin
            pfirst_q <= 1'b0;
            prev_q   <= brd;
            if (!pfirst_q && brd[6] != prev_q[6]) begin
              tog_q <= 1'b1;
            end
            // done when bit seven shows the true value and bit six stops;
            // unlock loads no byte, so only the toggle bit or the write cycle timeout can end it
            if (!pfirst_q && brd[6] == prev_q[6] && (brd[7] == last_q[7] || op == EEWC_OP_UNLOCK)) begin
              tmr_q <= 24'd0;
              st_q  <= EEWC_HOLD;
            end
          end
          if (tmr_q >= 24'(WRITE_CYC)) begin
            tmo_q <= 1'b1;
            tmr_q <= 24'd0;
            st_q  <= EEWC_HOLD;
          end
        end
        default: begin
          // no strobes while device writes; protect/reset held high
          tmr_q <= tmr_q + 24'd1;
          // with the protect bit set the pin stays high after idle anyway, so the
          // 10 ms count only matters once software has let the bit go
          if (ready_busy_n && (ctrl_q[CTRL_PROT_BIT] || tmr_q >= 24'(RESET_HOLD_CYC))) begin
            st_q <= EEWC_IDLE;
          end
        end
      endcase
    end
  end

  ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == EEWC_IDLE && $past(st_q) == EEWC_HOLD) |-> $past(ready_busy_n)) else $error("idle before ready");
  prot_a: assert property (@(posedge pclk) disable iff (!presetn)
    !mem_ce_n |-> protect_reset_n) else $error("protect low while selected");
  inhibit_a: assert property (@(posedge pclk) disable iff (!presetn)
    !mem_we_n |-> (!mem_ce_n && mem_oe_n)) else $error("write strobe with inhibit");
  strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(mem_we_n) |-> !mem_we_n [*3]) else $error("write strobe too short");
  addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    !mem_we_n |-> $stable(mem_addr) && $stable(mem_dq_out)) else $error("bus moved under strobe");
  quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == EEWC_GAP || st_q == EEWC_HOLD) |-> mem_we_n) else $error("strobe during write");
  len_a: assert property (@(posedge pclk) disable iff (!presetn)
    bidx_q <= 7'd64) else $error("page overrun");
  unl_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == EEWC_CODE && op == EEWC_OP_UNLOCK) |=> st_q != EEWC_LOAD)
    else $error("data after unlock");
  c_write: cover property (@(posedge pclk) st_q == EEWC_GAP ##1 st_q == EEWC_POLL);
  c_unlock: cover property (@(posedge pclk) st_q == EEWC_CODE && op == EEWC_OP_UNLOCK);
  c_tog: cover property (@(posedge pclk) tog_q);
endmodule
`default_nettype wire

// File: sim/eewc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural memory device seen from the controller pins
module eewc_dev_model
  import eewc_pkg::*;
#(
  parameter int WR_CYC  = 5000, // internal write, well inside 10 ms
  parameter int WIN_CYC = 2500  // 100 us idle window at 40 ns
) (
  input  wire logic        pclk,
  input  wire logic [14:0] a,
  input  wire logic [7:0]  dq_w,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        protect_reset_n,
  output logic      [7:0]  dq_r,
  output logic             rb_low
);
  logic [7:0]  mem [0:32767]; // array, erased to ff
  logic [7:0]  bd  [0:63];    // page buffer data
  logic [5:0]  bo  [0:63];    // page buffer offsets
  logic [8:0]  page;          // row of the current load
  logic [14:0] la;            // latched write address
  logic [7:0]  last;          // last loaded byte
  logic        we_q, oe_q, busy, tog, lock, arm, pend, drv, drv_q, rbl; // rbl: ready/busy held low
  int          nb, idle, cnt, seq;
  logic [14:0] ea  [0:5] = '{CMD_ADDR_A, CMD_ADDR_B, CMD_ADDR_A, CMD_ADDR_A, CMD_ADDR_B, CMD_ADDR_A};
  logic [7:0]  ed  [0:5] = '{CMD_DAT_AA, CMD_DAT_55, CMD_DAT_80, CMD_DAT_AA, CMD_DAT_55, CMD_DAT_UNLOCK};

  // lock is off as delivered
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {we_q, oe_q, busy, tog, lock, arm, pend, drv, drv_q, rbl} = 10'h300;
    {nb, idle, cnt, seq} = '0;
    {dq_r, rb_low, page, la, last} = '0;
  end

  // one byte load; command codes are swallowed, never stored
  task automatic load(input logic [14:0] ad, input logic [7:0] d);
    if (seq == 2 && ad == CMD_ADDR_A && d == CMD_DAT_LOCK) begin
      arm = 1'b1;
      seq = 0;
    end else if (ad == ea[seq] && d == ed[seq]) begin
      seq = seq + 1;
      if (seq == 6) begin
        lock = 1'b0;
        seq  = 0;
      end
    end else begin
      seq = 0;
      // locked device drops plain writes
      if ((!lock || arm) && nb < PAGE_BYTES) begin
        if (nb == 0) page = ad[14:6];
        bo[nb] = ad[5:0];
        bd[nb] = d;
        nb++;
        last   = d;
        rbl    = 1'b1;
        pend   = pend | arm;
        idle   = 0;
      end
    end
  endtask

  // sampling at 40 ns misses a pulse of 20 ns or less only when no rising edge falls inside it
  always @(posedge pclk) begin
    if (!protect_reset_n) begin
      busy   = 1'b0;
      nb     = 0;
      rbl    = 1'b0;
      drv    = 1'b0;
    end else begin
      if (we_q && !we_n && !ce_n) la = a;
      if (!we_q && we_n && !ce_n && oe_n && !busy) load(la, dq_w);
      if (busy && !oe_q && oe_n) tog = ~tog;
      if (nb > 0 && !busy) begin
        idle = (we_n || ce_n) ? idle + 1 : 0;
        if (idle >= WIN_CYC) begin
          busy = 1'b1;
          cnt  = 0;
          tog  = 1'b1;
        end
      end else if (busy) begin
        cnt++;
        if (cnt >= WR_CYC) begin
          for (int i = 0; i < nb; i++) mem[{page, bo[i]}] = bd[i];
          lock   = lock | pend;
          {arm, pend, busy, rbl} = 4'h0;
          nb     = 0;
        end
      end
      drv = !ce_n && !oe_n && we_n;
    end
    // a released bus shows the inverse rather than a stale value
    // pins move by non-blocking assignment: the controller samples them on the
    // same edge, and a blocking update here would race its flip-flops
    if (drv) dq_r <= busy ? {~last[7], tog, last[5:0]} : mem[a];
    else if (drv_q) dq_r <= ~dq_r;
    rb_low <= rbl;
    drv_q = drv;
    we_q  = we_n;
    oe_q  = oe_n;
  end
endmodule
`default_nettype wire

// File: sim/test_eewc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_eewc_ctrl;
  import eewc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, mem_dq_oe, mem_ce_n, mem_oe_n, mem_we_n, protect_reset_n, rb_low;
  logic [14:0] mem_addr, t1, t2;
  logic [7:0]  mem_dq_out, dev_dq, d1;
  logic [8:0]  pg;
  logic [7:0]  exp_pg [0:63];   // bytes pushed by run
  logic [31:0] seed = 32'h6FC94D3E;
  int          error_cnt = 0, checked = 0, cyc = 0;
  wire logic   ready_busy_n;

  // open drain with pull-up
  assign ready_busy_n = rb_low ? 1'b0 : 1'b1;

  always #20 pclk = ~pclk;

  eewc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .mem_dq_in(dev_dq), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
    .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
    .protect_reset_n(protect_reset_n), .ready_busy_n(ready_busy_n));

  eewc_dev_model dev (.pclk(pclk), .a(mem_addr), .dq_w(mem_dq_out), .ce_n(mem_ce_n), .oe_n(mem_oe_n),
    .we_n(mem_we_n), .protect_reset_n(protect_reset_n), .dq_r(dev_dq), .rb_low(rb_low));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // go, op, protect high and length (64 goes out as 0, which means 64; n of 0 goes out as 1)
  function automatic logic [31:0] ctrl_word(input eewc_op_t op, input int n);
    logic [31:0] w;
    w = 32'h0000_0001 << CTRL_GO_BIT;
    w |= 32'(op) << CTRL_OP_LSB;
    w |= 32'h0000_0001 << CTRL_PROT_BIT;
    w |= 32'((n == 0 ? 1 : n) % 64) << CTRL_LEN_LSB;
    return w;
  endfunction

  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard: four writes of about 8k cycles, two short ones of about 2.6k and 69 short reads need about 40k
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 80_000) begin
      error_cnt++;
      print_verdict;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // setup then access; hold until pready seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle;
    for (int n = 0; n < 300000; n++) begin
      apb(1'b0, REG_STATUS, '0);
      if (rd[ST_BUSY_BIT] === 1'b0) break;
    end
  endtask

  task automatic run(input eewc_op_t op, input logic [14:0] ad, input int n);
    apb(1'b1, REG_ADDR, 32'(ad));
    for (int i = 0; i < n; i++) apb(1'b1, REG_DATA, 32'(exp_pg[i]));
    apb(1'b1, REG_CTRL, ctrl_word(op, n));
  endtask

  task automatic wr1(input eewc_op_t op, input logic [14:0] ad, input logic [7:0] d);
    exp_pg[0] = d;
    run(op, ad, 1);
    wait_idle;
  endtask

  task automatic rd_chk(input logic [14:0] ad, input logic [7:0] exp);
    run(EEWC_OP_READ, ad, 0);
    wait_idle;
    apb(1'b0, REG_RDATA, '0);
    chk(rd, {24'h00_0000, exp});
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({mem_we_n, mem_ce_n, mem_oe_n, protect_reset_n, mem_dq_oe}), 32'h1C);
    apb(1'b0, REG_CTRL, '0);
    chk(rd, CTRL_RST);
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    apb(1'b0, 12'h020, '0);
    chk(rd, 32'h0);
    // full random page, rows kept clear of the command addresses
    seed = xs(seed);
    pg = {2'b11, seed[6:0]};
    t1 = {9'h010, seed[13:8]};
    t2 = {9'h011, seed[21:16]};
    for (int i = 0; i < 64; i++) begin
      seed = xs(seed);
      exp_pg[i] = seed[7:0];
    end
    run(EEWC_OP_WRITE, {pg, 6'h00}, 64);
    repeat (4000) @(posedge pclk);
    apb(1'b0, REG_STATUS, '0);
    chk(32'(rd[ST_RDY_BIT]), 32'h0);
    wait_idle;
    apb(1'b0, REG_STATUS, '0);
    chk(32'(rd[3:1]), 32'h5);
    for (int i = 0; i < 64; i++) rd_chk({pg, 6'(i)}, exp_pg[i]);
    d1 = seed[31:24];
    wr1(EEWC_OP_LOCK, t1, d1);
    rd_chk(t1, d1);
    wr1(EEWC_OP_WRITE, t1, d1 ^ 8'h01);
    rd_chk(t1, d1);
    wr1(EEWC_OP_LWRITE, t1, ~d1);
    rd_chk(t1, ~d1);
    run(EEWC_OP_UNLOCK, CMD_ADDR_A, 0);
    wait_idle;
    rd_chk(CMD_ADDR_A, 8'hFF);
    wr1(EEWC_OP_WRITE, t2, d1);
    rd_chk(t2, d1);
    print_verdict;
  end
endmodule
`default_nettype wire
